// >>> core/dtc_map.vh
/*
 * register map, field positions, reset values and timing counts of the
 * dual timer/counter unit; definitions only, included by bare name
 */
`ifndef DTC_MAP_VH
`define DTC_MAP_VH

// byte addresses on the apb bus
`define DTC_ADDR_MODE 12'h000
`define DTC_ADDR_CTRL 12'h004
`define DTC_ADDR_A_LOW 12'h008
`define DTC_ADDR_A_HIGH 12'h00c
`define DTC_ADDR_B_LOW 12'h010
`define DTC_ADDR_B_HIGH 12'h014
`define DTC_ADDR_ACK 12'h018
`define DTC_ADDR_OPT 12'h01c

// control register bit positions
`define DTC_CTRL_B_OVF 7
`define DTC_CTRL_B_RUN 6
`define DTC_CTRL_A_OVF 5
`define DTC_CTRL_A_RUN 4
`define DTC_CTRL_B_IRQ 3
`define DTC_CTRL_B_TYPE 2
`define DTC_CTRL_A_IRQ 1
`define DTC_CTRL_A_TYPE 0

// mode nibble fields
`define DTC_MODE_GATE 3
`define DTC_MODE_FUNC 2
`define DTC_MODE_13 2'h0
`define DTC_MODE_16 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

// reset values
`define DTC_MODE_RESET 8'h00
`define DTC_CTRL_RESET 8'h00
`define DTC_OPT_RESET 1'h1

// oscillator periods per machine cycle
`define DTC_PERIODS_12T 4'hc
`define DTC_PERIODS_6T 4'h6

`endif

// >>> core/dtc_timer_unit.v
/*
 * dual 16-bit timer/counter with apb register slave.
 * assumes pclk is the oscillator clock, event and interrupt pins are
 * already synchronous to pclk, and the cpu's vector acknowledge reaches
 * the block as writes to the acknowledge register.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dtc_map.vh"

module dtc_timer_unit #(
    parameter PERIODS_12T = `DTC_PERIODS_12T,
    parameter PERIODS_6T = `DTC_PERIODS_6T
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire cycle_length_option,
    input wire unit_a_event_pin,
    input wire unit_b_event_pin,
    input wire ext_irq_a_pin,
    input wire ext_irq_b_pin,
    output reg unit_a_overflow_flag,
    output reg unit_b_overflow_flag,
    output reg ext_irq_a_flag,
    output reg ext_irq_b_flag
);

    reg [7:0] mode_reg;
    reg unit_a_run_reg;
    reg unit_b_run_reg;
    reg a_type_reg;
    reg b_type_reg;
    reg [7:0] a_low_reg;
    reg [7:0] a_high_reg;
    reg [7:0] b_low_reg;
    reg [7:0] b_high_reg;
    reg opt_reg;
    reg [3:0] div_reg;
    reg ev_a_reg;
    reg ev_b_reg;
    reg irq_a_reg;
    reg irq_b_reg;
    reg seen_reg;

    // advance decision for one unit, shared by both units
    function tick_en;
        input [3:0] nib;
        input run;
        input pin;
        input fall;
        input mc;
        begin
            tick_en = run && (!nib[`DTC_MODE_GATE] || pin) &&
                (nib[`DTC_MODE_FUNC] ? fall : mc);
        end
    endfunction

    // write strobe for one register word; refused addresses never match
    function wr_hit;
        input [11:0] addr;
        input [11:0] target;
        input strobe;
        begin
            wr_hit = strobe && (addr == target);
        end
    endfunction

    wire [3:0] periods = opt_reg ? PERIODS_12T[3:0] : PERIODS_6T[3:0];
    wire mc = (div_reg == periods - 4'h1);
    wire [3:0] nib_a = mode_reg[3:0];
    wire [3:0] nib_b = mode_reg[7:4];
    wire fall_a = mc && ev_a_reg && !unit_a_event_pin;
    wire fall_b = mc && ev_b_reg && !unit_b_event_pin;
    wire go_a = tick_en(nib_a, unit_a_run_reg, ext_irq_a_pin, fall_a, mc);
    wire go_b = tick_en(nib_b, unit_b_run_reg, ext_irq_b_pin, fall_b, mc);
    // split high byte: timer only, steered by unit b run bit
    wire go_ah = mc && unit_b_run_reg;
    wire split_a = nib_a[1:0] == `DTC_MODE_SPLIT;
    wire wr = psel && penable && pwrite && pready;
    wire rd = psel && !penable && !pwrite;
    wire [7:0] wd = pwdata[7:0];
    wire wr_mode = wr_hit(paddr, `DTC_ADDR_MODE, wr);
    wire wr_ctrl = wr_hit(paddr, `DTC_ADDR_CTRL, wr);
    wire wr_ack = wr_hit(paddr, `DTC_ADDR_ACK, wr);
    wire wr_a_low = wr_hit(paddr, `DTC_ADDR_A_LOW, wr);
    wire wr_a_high = wr_hit(paddr, `DTC_ADDR_A_HIGH, wr);
    wire wr_b_low = wr_hit(paddr, `DTC_ADDR_B_LOW, wr);
    wire wr_b_high = wr_hit(paddr, `DTC_ADDR_B_HIGH, wr);
    // level mode keeps setting the flag while its pin stays low, so an
    // acknowledge only sticks once the pin has gone high again
    wire irq_a_cond = a_type_reg ? (irq_a_reg && !ext_irq_a_pin) : !ext_irq_a_pin;
    wire irq_b_cond = b_type_reg ? (irq_b_reg && !ext_irq_b_pin) : !ext_irq_b_pin;

    // counting of one unit: returns {overflow, high, low}
    // 13-bit mode leaves the top three low-byte bits as written; they never
    // carry into the high byte
    function [16:0] step;
        input [1:0] md;
        input [7:0] lo;
        input [7:0] hi;
        input isb;
        reg [8:0] l9;
        reg [13:0] c13;
        reg [16:0] c16;
        begin
            l9 = {1'b0, lo} + 9'h001;
            c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
            c16 = {1'b0, hi, lo} + 17'h00001;
            case (md)
                `DTC_MODE_13: step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
                `DTC_MODE_16: step = c16;
                `DTC_MODE_RELOAD: step = {l9[8], hi, l9[8] ? hi : l9[7:0]};
                `DTC_MODE_SPLIT: step = isb ? {1'b0, hi, lo} : {l9[8], hi, l9[7:0]};
                default: step = {1'b0, hi, lo};
            endcase
        end
    endfunction

    wire [16:0] nx_a = step(nib_a[1:0], a_low_reg, a_high_reg, 1'b0);
    wire [16:0] nx_b = step(nib_b[1:0], b_low_reg, b_high_reg, 1'b1);
    wire [8:0] ah9 = {1'b0, a_high_reg} + 9'h001;
    wire ovf_a = go_a && nx_a[16];
    wire ovf_b = split_a ? (go_ah && ah9[8]) : (go_b && nx_b[16]);

    // machine-cycle divider, once-per-cycle event pin samples and per-clock irq pin samples
    // the divider free-runs from reset, so the first tick after a run write
    // lands anywhere within one machine cycle; software sees that jitter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 4'h0;
            ev_a_reg <= 1'b1;
            ev_b_reg <= 1'b1;
            irq_a_reg <= 1'b1;
            irq_b_reg <= 1'b1;
        end else begin
            div_reg <= mc ? 4'h0 : div_reg + 4'h1;
            irq_a_reg <= ext_irq_a_pin;
            irq_b_reg <= ext_irq_b_pin;
            if (mc) begin
                ev_a_reg <= unit_a_event_pin;
                ev_b_reg <= unit_b_event_pin;
            end
        end
    end

    // option bit is caught once after reset release, never under reset
    // changing the option pin later has no effect until the next reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_reg <= `DTC_OPT_RESET;
            seen_reg <= 1'b0;
        end else if (!seen_reg) begin
            opt_reg <= cycle_length_option;
            seen_reg <= 1'b1;
        end
    end

    // counters; software writes win over a count in the same cycle
    // a split unit a takes its high byte off the unit b run bit; unit b keeps
    // counting in its own mode but its flag then belongs to that high byte
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_low_reg <= 8'h00;
            a_high_reg <= 8'h00;
            b_low_reg <= 8'h00;
            b_high_reg <= 8'h00;
        end else begin
            if (wr_a_low) begin
                a_low_reg <= wd;
            end else if (go_a) begin
                a_low_reg <= nx_a[7:0];
            end
            if (wr_a_high) begin
                a_high_reg <= wd;
            end else if (split_a) begin
                if (go_ah) begin
                    a_high_reg <= ah9[7:0];
                end
            end else if (go_a) begin
                a_high_reg <= nx_a[15:8];
            end
            if (wr_b_low) begin
                b_low_reg <= wd;
            end else if (go_b) begin
                b_low_reg <= nx_b[7:0];
            end
            if (wr_b_high) begin
                b_high_reg <= wd;
            end else if (go_b) begin
                b_high_reg <= nx_b[15:8];
            end
        end
    end

    // control register; hardware set wins over any clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= `DTC_MODE_RESET;
            unit_a_run_reg <= 1'b0;
            unit_b_run_reg <= 1'b0;
            a_type_reg <= 1'b0;
            b_type_reg <= 1'b0;
            unit_a_overflow_flag <= 1'b0;
            unit_b_overflow_flag <= 1'b0;
            ext_irq_a_flag <= 1'b0;
            ext_irq_b_flag <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode_reg <= wd;
            end
            if (wr_ctrl) begin
                unit_a_run_reg <= wd[`DTC_CTRL_A_RUN];
                unit_b_run_reg <= wd[`DTC_CTRL_B_RUN];
                a_type_reg <= wd[`DTC_CTRL_A_TYPE];
                b_type_reg <= wd[`DTC_CTRL_B_TYPE];
            end
            // a write of zero or a vector acknowledge clears the flag
            if (ovf_a) begin
                unit_a_overflow_flag <= 1'b1;
            end else if ((wr_ctrl && !wd[`DTC_CTRL_A_OVF]) || (wr_ack && wd[`DTC_CTRL_A_OVF])) begin
                unit_a_overflow_flag <= 1'b0;
            end
            if (ovf_b) begin
                unit_b_overflow_flag <= 1'b1;
            end else if ((wr_ctrl && !wd[`DTC_CTRL_B_OVF]) || (wr_ack && wd[`DTC_CTRL_B_OVF])) begin
                unit_b_overflow_flag <= 1'b0;
            end
            // interrupt processed is signalled through the acknowledge register
            if (irq_a_cond) begin
                ext_irq_a_flag <= 1'b1;
            end else if (wr_ack && wd[`DTC_CTRL_A_IRQ]) begin
                ext_irq_a_flag <= 1'b0;
            end
            if (irq_b_cond) begin
                ext_irq_b_flag <= 1'b1;
            end else if (wr_ack && wd[`DTC_CTRL_B_IRQ]) begin
                ext_irq_b_flag <= 1'b0;
            end
        end
    end

    // apb slave: no wait state, read data latched in the setup cycle
    // refused transfers still answer with no wait state; a refused write
    // matches no register and is dropped
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr[1:0] != 2'h0 || paddr > `DTC_ADDR_OPT);
            if (rd) begin
                case (paddr)
                    `DTC_ADDR_MODE: prdata <= {24'h000000, mode_reg};
                    `DTC_ADDR_CTRL: prdata <= {24'h000000, unit_b_overflow_flag,
                        unit_b_run_reg, unit_a_overflow_flag, unit_a_run_reg,
                        ext_irq_b_flag, b_type_reg, ext_irq_a_flag, a_type_reg};
                    `DTC_ADDR_A_LOW: prdata <= {24'h000000, a_low_reg};
                    `DTC_ADDR_A_HIGH: prdata <= {24'h000000, a_high_reg};
                    `DTC_ADDR_B_LOW: prdata <= {24'h000000, b_low_reg};
                    `DTC_ADDR_B_HIGH: prdata <= {24'h000000, b_high_reg};
                    `DTC_ADDR_OPT: prdata <= {31'h00000000, opt_reg};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// >>> tb/dtc_pin_model.sv
/*
 * board side of the timer: event pins and external interrupt pins.
 * assumes the bench calls its tasks right after a rising pclk edge.
 */
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_model (
    input wire logic pclk,
    output logic evt_a,
    output logic evt_b,
    output logic irq_a,
    output logic irq_b
);
    // pins idle high so no stray fall is counted at start
    initial begin
        evt_a = 1'b1;
        evt_b = 1'b1;
        irq_a = 1'b1;
        irq_b = 1'b1;
    end
    // both levels held w clocks, long against a machine cycle
    task automatic pulses(input int n, input int w);
        repeat (n) begin
            repeat (w) @(posedge pclk);
            evt_a <= 1'b0;
            repeat (w) @(posedge pclk);
            evt_a <= 1'b1;
        end
    endtask
    task automatic set_irq(input logic a, input logic b);
        irq_a <= a;
        irq_b <= b;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// >>> tb/dtc_timer_props.sv
/*
 * port checker for the dual timer/counter: apb timing, decode, flags.
 * assumes it is bound onto dtc_timer_unit, one clock, async low reset.
 */
`timescale 1ns/100ps
`default_nettype none
module dtc_timer_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic unit_a_overflow_flag,
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_a_flag
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a write lands at the access edge, so flag clears trace back to it
    logic wr_done;
    assign wr_done = psel && penable && pready && pwrite;
    sequence setup_s; psel && !penable; endsequence
    sequence access_s; psel && penable && pready; endsequence
    ready_phase_a: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    answer_next_a: assert property (setup_s |=> access_s)
        else $error("no ready right after setup");
    bad_addr_a: assert property (pready && paddr > 12'h01c |-> pslverr)
        else $error("unmapped address not refused");
    unaligned_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned address not refused");
    byte_regs_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data above byte");
    ack_zero_a: assert property (access_s and (!pwrite && paddr == 12'h018) |-> prdata == 32'h0)
        else $error("acknowledge register reads nonzero");
    ovf_clear_a: assert property ($fell(unit_a_overflow_flag) |-> $past(wr_done))
        else $error("overflow flag cleared without a write");
    irq_clear_a: assert property ($fell(ext_irq_a_flag) |-> $past(wr_done && paddr == 12'h018))
        else $error("irq flag cleared without acknowledge");
    irq_cause_a: assert property ($rose(ext_irq_a_flag) |-> !$past(ext_irq_a_pin))
        else $error("irq flag set while pin high");
endmodule
`default_nettype wire

// >>> tb/dtc_timer_unit_bench.sv
/*
 * self-checking bench for dtc_timer_unit, expectations from integer maths.
 * assumes dtc_pin_model drives the pins and dtc_timer_props is bound.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dtc_map.vh"
module dtc_timer_unit_bench;
    logic pclk, presetn, psel, penable, pwrite, opt, err, c;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic pready, pslverr, ovf_a, ovf_b, irq_a, irq_b;
    wire logic ea, eb, ia, ib;
    int errors, compares;
    dtc_timer_unit dtc_timer_unit_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cycle_length_option(opt),
        .unit_a_event_pin(ea), .unit_b_event_pin(eb), .ext_irq_a_pin(ia), .ext_irq_b_pin(ib),
        .unit_a_overflow_flag(ovf_a), .unit_b_overflow_flag(ovf_b),
        .ext_irq_a_flag(irq_a), .ext_irq_b_flag(irq_b));
    dtc_pin_model dtc_pin_model_inst (.pclk(pclk), .evt_a(ea), .evt_b(eb), .irq_a(ia),
        .irq_b(ib));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t %h %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // one apb transfer, held until ready, then an idle edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_ovf(input int lim, input logic sel_b, output int n);
        n = 0;
        while ((sel_b ? ovf_b : ovf_a) !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        if (n >= lim) begin
            errors++;
            finish_test();
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // hang guard far above the bench's run time
    initial begin
        #700000;
        errors++;
        finish_test();
    end
    initial begin : main
        int n, per, k, j;
        logic [7:0] m, hi;
        seed = 32'h5baba09d;
        {psel, penable, pwrite, paddr, pwdata, presetn, opt} = '0;
        errors = 0;
        compares = 0;
        // 12-clock cycles first, then a second reset into 6-clock cycles
        for (k = 0; k < 2; k++) begin
            @(posedge pclk);
            presetn <= 1'b0;
            opt <= (k == 0);
            per = (k == 0) ? 12 : 6;
            repeat (10) @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
            apb(0, `DTC_ADDR_MODE, 0);
            check(rd, {24'h0, `DTC_MODE_RESET});
            apb(0, `DTC_ADDR_CTRL, 0);
            check(rd, {24'h0, `DTC_CTRL_RESET});
            apb(0, `DTC_ADDR_OPT, 0);
            check(rd, {31'h0, k == 0});
            m = rnd();
            apb(1, `DTC_ADDR_MODE, {24'h0, m});
            apb(0, `DTC_ADDR_MODE, 0);
            check(rd, {24'h0, m});
            apb(1, 12'h020, rnd());
            check({31'h0, err}, 32'h1);
            apb(0, 12'h006, 0);
            check({31'h0, err}, 32'h1);
            // four ticks to overflow in 13-bit, 16-bit and reload modes
            for (j = 0; j < 3; j++) begin
                hi = (j == 2) ? 8'h5a : 8'hff;
                apb(1, `DTC_ADDR_MODE, j);
                apb(1, `DTC_ADDR_A_LOW, 32'hfc);
                apb(1, `DTC_ADDR_A_HIGH, {24'h0, hi});
                apb(1, `DTC_ADDR_CTRL, 32'h10);
                wait_ovf(100, 1'b0, n);
                c = n >= 3 * per - 2 && n <= 4 * per + 4;
                check({31'h0, c}, 32'h1);
                apb(1, `DTC_ADDR_CTRL, 0);
                check({31'h0, ovf_a}, 32'h0);
                apb(0, `DTC_ADDR_A_HIGH, 0);
                check(rd, (j == 2) ? 32'h5a : 32'h0);
                apb(0, `DTC_ADDR_A_LOW, 0);
                check(rd, (j == 0) ? 32'he0 : (j == 1) ? 32'h0 : 32'h5a);
            end
            // counter function: three falls from fd roll over to zero
            apb(1, `DTC_ADDR_MODE, 32'h05);
            apb(1, `DTC_ADDR_A_LOW, 32'hfd);
            apb(1, `DTC_ADDR_A_HIGH, 32'hff);
            apb(1, `DTC_ADDR_CTRL, 32'h10);
            dtc_pin_model_inst.pulses(2, 3 * per);
            check({31'h0, ovf_a}, 32'h0);
            dtc_pin_model_inst.pulses(1, 3 * per);
            wait_ovf(4 * per, 1'b0, n);
            apb(0, `DTC_ADDR_A_LOW, 0);
            check(rd, 32'h0);
            // unit a gated by low irq pin, unit b in mode 3 holds
            dtc_pin_model_inst.set_irq(0, 1);
            apb(1, `DTC_ADDR_MODE, 32'h39);
            apb(1, `DTC_ADDR_A_LOW, 0);
            apb(1, `DTC_ADDR_B_LOW, 32'h33);
            apb(1, `DTC_ADDR_CTRL, 32'h50);
            repeat (4 * per) @(posedge pclk);
            apb(0, `DTC_ADDR_A_LOW, 0);
            check(rd, 32'h0);
            apb(0, `DTC_ADDR_B_LOW, 0);
            check(rd, 32'h33);
            apb(0, `DTC_ADDR_CTRL, 0);
            check(rd & 32'hf3, 32'h52);
            dtc_pin_model_inst.set_irq(1, 1);
            apb(1, `DTC_ADDR_ACK, 32'h2);
            check({31'h0, irq_a}, 32'h0);
            repeat (4 * per) @(posedge pclk);
            apb(0, `DTC_ADDR_A_LOW, 0);
            c = rd >= 3 && rd <= 6;
            check({31'h0, c}, 32'h1);
            // edge type: flag set by the fall, stays clear while pin low
            apb(1, `DTC_ADDR_CTRL, 32'h4);
            dtc_pin_model_inst.set_irq(1, 0);
            repeat (3) @(posedge pclk);
            check({31'h0, irq_b}, 32'h1);
            apb(1, `DTC_ADDR_ACK, 32'h8);
            repeat (3) @(posedge pclk);
            check({31'h0, irq_b}, 32'h0);
            dtc_pin_model_inst.set_irq(1, 1);
            // split unit a: high byte times off the unit b run bit and flag
            apb(1, `DTC_ADDR_MODE, 32'h33);
            apb(1, `DTC_ADDR_A_LOW, 32'h80);
            apb(1, `DTC_ADDR_A_HIGH, 32'hfc);
            apb(1, `DTC_ADDR_CTRL, 32'h40);
            wait_ovf(100, 1'b1, n);
            c = n >= 3 * per - 2 && n <= 4 * per + 4;
            check({31'h0, c}, 32'h1);
            check({31'h0, ovf_a}, 32'h0);
            apb(1, `DTC_ADDR_CTRL, 0);
            check({31'h0, ovf_b}, 32'h0);
            apb(0, `DTC_ADDR_A_HIGH, 0);
            check(rd, 32'h0);
            apb(0, `DTC_ADDR_A_LOW, 0);
            check(rd, 32'h80);
            apb(0, `DTC_ADDR_ACK, 0);
            check(rd, 32'h0);
        end
        finish_test();
    end
endmodule
bind dtc_timer_unit dtc_timer_props dtc_timer_props_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .unit_a_overflow_flag(unit_a_overflow_flag),
    .ext_irq_a_pin(ext_irq_a_pin), .ext_irq_a_flag(ext_irq_a_flag));
`default_nettype wire
